// *** core/scf_clock_timing.sv ***
// clock generation, pll bypass, spread spectrum and line/frame timing of the sensor
// assumes i_clk is the reference clock and the control block hands over decoded register accesses
`timescale 1ns/1ps
`include "scf_regs.svh"
module scf_clock_timing
  import scf_pkg::*;
(
  // clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  // register port
  input  wire logic            i_reg_wr,
  input  wire logic [15:0]     i_reg_addr,
  input  wire logic [15:0]     i_reg_wdata,
  output logic      [15:0]     o_reg_rdata,
  // timing and exposure outputs
  output scf_timing_type       o_timing,
  output scf_expo_type         o_expo,
  output logic                 o_streaming
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  scf_pll_type   pll_q, pll_d, pll_act_q, pll_act_d;
  scf_ssc_type   ssc_q, ssc_d, ssc_act_q, ssc_act_d;
  scf_expo_type  expo_q, expo_d;
  logic [7:0]    ref_q, ref_d;
  logic [15:0]   line_q, line_d, frame_q, frame_d, xsz_q, xsz_d, ysz_q, ysz_d;
  logic          stream_req_q, stream_req_d, mirror_q, mirror_d, flip_q, flip_d;
  logic [15:0]   rdata_d;
  scf_mode_type  mode_q, mode_d;
  logic          sel_pll;

  always_comb begin
    pll_d        = pll_q;
    ssc_d        = ssc_q;
    expo_d       = expo_q;
    ref_d        = ref_q;
    line_d       = line_q;
    frame_d      = frame_q;
    xsz_d        = xsz_q;
    ysz_d        = ysz_q;
    stream_req_d = stream_req_q;
    mirror_d     = mirror_q;
    flip_d       = flip_q;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `SCF_A_MODE:      stream_req_d = i_reg_wdata[`SCF_B_STREAM];
        `SCF_A_ORIENT: begin
          mirror_d = i_reg_wdata[`SCF_B_MIRROR];
          flip_d   = i_reg_wdata[`SCF_B_FLIP];
        end
        `SCF_A_INT_LONG:  expo_d.int_long = i_reg_wdata;
        `SCF_A_AGAIN:     expo_d.analog_gain = i_reg_wdata[7:0];
        `SCF_A_DGAIN:     expo_d.digital_gain = i_reg_wdata;
        `SCF_A_VT_PIX:    pll_d.vt_pix = i_reg_wdata[7:0];
        `SCF_A_VT_SYS:    pll_d.vt_sys = i_reg_wdata[7:0];
        `SCF_A_PREDIV:    pll_d.prediv = i_reg_wdata[7:0];
        `SCF_A_MULT:      pll_d.mult = i_reg_wdata;
        `SCF_A_OP_PIX:    pll_d.op_pix = i_reg_wdata[7:0];
        `SCF_A_OP_SYS:    pll_d.op_sys = i_reg_wdata[7:0];
        `SCF_A_REF_MHZ:   ref_d = i_reg_wdata[7:0];
        `SCF_A_LINE_LEN:  line_d = i_reg_wdata;
        `SCF_A_X_SIZE:    xsz_d = i_reg_wdata;
        `SCF_A_Y_SIZE:    ysz_d = i_reg_wdata;
        `SCF_A_FRAME_LEN: frame_d = i_reg_wdata;
        `SCF_A_SSC_CTRL: begin
          ssc_d.en   = i_reg_wdata[`SCF_B_SSC_EN];
          ssc_d.down = i_reg_wdata[`SCF_B_SSC_DOWN];
        end
        `SCF_A_SSC_PER:   ssc_d.period = i_reg_wdata;
        `SCF_A_SSC_DEPTH: ssc_d.depth = i_reg_wdata[7:0];
        default: ;
      endcase
    end
    // written values wait in shadows; the running pll only sees them in standby
    pll_act_d = (mode_q == SCF_STANDBY) ? pll_q : pll_act_q;
    ssc_act_d = (mode_q == SCF_STANDBY) ? ssc_q : ssc_act_q;
    unique case (i_reg_addr)
      `SCF_A_MODE:      rdata_d = {15'h0000, stream_req_q};
      `SCF_A_ORIENT:    rdata_d = {14'h0000, flip_q, mirror_q};
      `SCF_A_INT_LONG:  rdata_d = expo_q.int_long;
      `SCF_A_AGAIN:     rdata_d = {8'h00, expo_q.analog_gain};
      `SCF_A_DGAIN:     rdata_d = expo_q.digital_gain;
      `SCF_A_VT_PIX:    rdata_d = {8'h00, pll_q.vt_pix};
      `SCF_A_VT_SYS:    rdata_d = {8'h00, pll_q.vt_sys};
      `SCF_A_PREDIV:    rdata_d = {8'h00, pll_q.prediv};
      `SCF_A_MULT:      rdata_d = pll_q.mult;
      `SCF_A_OP_PIX:    rdata_d = {8'h00, pll_q.op_pix};
      `SCF_A_OP_SYS:    rdata_d = {8'h00, pll_q.op_sys};
      `SCF_A_REF_MHZ:   rdata_d = {8'h00, ref_q};
      `SCF_A_LINE_LEN:  rdata_d = line_q;
      `SCF_A_X_SIZE:    rdata_d = xsz_q;
      `SCF_A_Y_SIZE:    rdata_d = ysz_q;
      `SCF_A_FRAME_LEN: rdata_d = frame_q;
      `SCF_A_SSC_CTRL:  rdata_d = {14'h0000, ssc_q.down, ssc_q.en};
      `SCF_A_SSC_PER:   rdata_d = ssc_q.period;
      `SCF_A_SSC_DEPTH: rdata_d = {8'h00, ssc_q.depth};
      `SCF_A_STATUS:    rdata_d = {14'h0000, sel_pll, o_streaming};
      default:          rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pll_q        <= {`SCF_R_PREDIV, `SCF_R_MULT, `SCF_R_VT_SYS, `SCF_R_VT_PIX, `SCF_R_OP_SYS, `SCF_R_OP_PIX};
      pll_act_q    <= {`SCF_R_PREDIV, `SCF_R_MULT, `SCF_R_VT_SYS, `SCF_R_VT_PIX, `SCF_R_OP_SYS, `SCF_R_OP_PIX};
      ssc_q        <= {1'b0, 1'b0, `SCF_R_SSC_PER, `SCF_R_SSC_DEPTH};
      ssc_act_q    <= {1'b0, 1'b0, `SCF_R_SSC_PER, `SCF_R_SSC_DEPTH};
      expo_q       <= '0;
      ref_q        <= `SCF_R_REF_MHZ;
      line_q       <= `SCF_R_LINE_LEN;
      frame_q      <= `SCF_R_FRAME_LEN;
      xsz_q        <= `SCF_R_X_SIZE;
      ysz_q        <= `SCF_R_Y_SIZE;
      stream_req_q <= 1'b0;
      mirror_q     <= 1'b0;
      flip_q       <= 1'b0;
      o_reg_rdata  <= 16'h0000;
    end else begin
      pll_q        <= pll_d;
      pll_act_q    <= pll_act_d;
      ssc_q        <= ssc_d;
      ssc_act_q    <= ssc_act_d;
      expo_q       <= expo_d;
      ref_q        <= ref_d;
      line_q       <= line_d;
      frame_q      <= frame_d;
      xsz_q        <= xsz_d;
      ysz_q        <= ysz_d;
      stream_req_q <= stream_req_d;
      mirror_q     <= mirror_d;
      flip_q       <= flip_d;
      o_reg_rdata  <= rdata_d;
    end
  end
  assign o_expo = expo_q;

  // ----------------------------------------
  // spread spectrum modulation of the multiplier
  // ----------------------------------------
  logic [15:0]       ssc_cnt_q, ssc_cnt_d;
  logic signed [9:0] ofs_q, ofs_d;
  logic              up_q, up_d;
  logic signed [9:0] ofs_hi, ofs_lo;
  logic [16:0]       mult_eff;

  always_comb begin
    ofs_hi    = ssc_act_q.down ? 10'sh000 : $signed({2'b00, ssc_act_q.depth});
    ofs_lo    = -$signed({2'b00, ssc_act_q.depth});
    ssc_cnt_d = ssc_cnt_q + 16'h0001;
    ofs_d     = ofs_q;
    up_d      = up_q;
    if (!ssc_act_q.en || !sel_pll) begin
      ssc_cnt_d = 16'h0000;
      ofs_d     = 10'sh000;
      up_d      = 1'b1;
    end else if (ssc_cnt_q >= ssc_act_q.period) begin
      ssc_cnt_d = 16'h0000;
      if (up_q && ofs_q >= ofs_hi) begin
        up_d  = 1'b0;
        ofs_d = ofs_q - 10'sh001;
      end else if (!up_q && ofs_q <= ofs_lo) begin
        up_d  = 1'b1;
        ofs_d = ofs_q + 10'sh001;
      end else begin
        ofs_d = up_q ? ofs_q + 10'sh001 : ofs_q - 10'sh001;
      end
    end
    mult_eff = 17'(pll_act_q.mult) + {{7{ofs_q[9]}}, ofs_q};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ssc_cnt_q <= 16'h0000;
      ofs_q     <= 10'sh000;
      up_q      <= 1'b1;
    end else begin
      ssc_cnt_q <= ssc_cnt_d;
      ofs_q     <= ofs_d;
      up_q      <= up_d;
    end
  end

  // ----------------------------------------
  // divider chains: [0] timing, [1] output
  // ----------------------------------------
  // rates above the reference saturate at one tick per reference edge
  logic [1:0] pll_tick;
  logic [1:0] raw_tick;
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_chain
    logic [25:0] acc_q, acc_d, sum;
    logic [24:0] den;
    always_comb begin
      den = (gi == 0) ? 25'({pll_act_q.prediv, 1'b0}) * 25'(pll_act_q.vt_sys) * 25'(pll_act_q.vt_pix)
                      : 25'({pll_act_q.prediv, 1'b0}) * 25'(pll_act_q.op_sys) * 25'(pll_act_q.op_pix);
      sum = acc_q + 26'(mult_eff);
      pll_tick[gi] = (sum >= 26'(den));
      acc_d = !pll_tick[gi] ? sum : (26'(mult_eff) >= 26'(den)) ? 26'h0000000 : sum - 26'(den);
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        acc_q <= 26'h0000000;
      end else begin
        acc_q <= acc_d;
      end
    end
    assign raw_tick[gi] = sel_pll ? pll_tick[gi] : 1'b1;
  end

  // ----------------------------------------
  // bypass / streaming control
  // ----------------------------------------
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      SCF_STANDBY: if (stream_req_q) mode_d = SCF_START;
      SCF_START:   if (pll_tick[0]) mode_d = SCF_STREAM;
      SCF_STREAM:  if (!stream_req_q) mode_d = SCF_STOP;
      SCF_STOP:    if (pll_tick[0]) mode_d = SCF_STANDBY;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= SCF_STANDBY;
    end else begin
      mode_q <= mode_d;
    end
  end
  assign sel_pll     = (mode_q == SCF_STREAM) || (mode_q == SCF_STOP);
  assign o_streaming = (mode_q == SCF_STREAM);

  // ----------------------------------------
  // line and frame timing
  // ----------------------------------------
  function automatic scf_color_type bayer(input logic hpar, input logic vpar);
    bayer = scf_color_type'({vpar, hpar});
  endfunction
  logic [15:0]    hcnt_q, hcnt_d, vcnt_q, vcnt_d;
  scf_timing_type tim_d;
  logic           line_end;
  always_comb begin
    line_end = (hcnt_q == line_q - 16'h0001);
    hcnt_d   = hcnt_q;
    vcnt_d   = vcnt_q;
    if (!o_streaming) begin
      hcnt_d = 16'h0000;
      vcnt_d = 16'h0000;
    end else if (raw_tick[0]) begin
      hcnt_d = line_end ? 16'h0000 : hcnt_q + 16'h0001;
      if (line_end) begin
        vcnt_d = (vcnt_q == frame_q - 16'h0001) ? 16'h0000 : vcnt_q + 16'h0001;
      end
    end
    tim_d.vt_tick     = raw_tick[0];
    tim_d.op_tick     = raw_tick[1];
    tim_d.line_blank  = o_streaming && (hcnt_q >= xsz_q);
    tim_d.frame_pad   = o_streaming && (vcnt_q >= ysz_q);
    tim_d.frame_start = o_streaming && raw_tick[0] && (hcnt_q == 16'h0000) && (vcnt_q == 16'h0000);
    tim_d.color       = bayer(hcnt_q[0] ^ mirror_q, vcnt_q[0] ^ flip_q);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hcnt_q   <= 16'h0000;
      vcnt_q   <= 16'h0000;
      o_timing <= '0;
    end else begin
      hcnt_q   <= hcnt_d;
      vcnt_q   <= vcnt_d;
      o_timing <= tim_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_PLL_LOAD_STANDBY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (pll_act_q != $past(pll_act_q)) |-> $past(mode_q) == SCF_STANDBY) else $error("pll changed outside standby");
  AST_BYPASS_EVERY_EDGE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_q == SCF_STANDBY) |=> o_timing.vt_tick && o_timing.op_tick) else $error("bypass missed a tick");
  AST_SSC_IDLE_FLAT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !ssc_act_q.en |=> ofs_q == 10'sh000) else $error("modulation while spread spectrum off");
  AST_SWITCH_ON_TICK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (sel_pll != $past(sel_pll)) |-> $past(pll_tick[0])) else $error("clock source switched off a tick");
  AST_LINE_WRAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_streaming && raw_tick[0] && line_end && stream_req_q) |=> hcnt_q == 16'h0000) else $error("line did not wrap");
  AST_LINE_STEP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_streaming && stream_req_q && !line_end) |=> hcnt_q == $past(hcnt_q) + {15'h0000, $past(raw_tick[0])})
    else $error("pixel count off");
  AST_BLANK_TAIL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_streaming && hcnt_q >= xsz_q) |=> o_timing.line_blank) else $error("blank pixel not flagged");
  AST_FIRST_PIXEL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (hcnt_q == 16'h0000 && vcnt_q == 16'h0000 && !mirror_q) |=>
      o_timing.color == ($past(flip_q) ? SCF_BLUE : SCF_GREEN_R)) else $error("wrong first bayer colour");
  AST_MIRROR_FIRST: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (hcnt_q == 16'h0000 && vcnt_q == 16'h0000 && mirror_q && !flip_q) |=> o_timing.color == SCF_RED)
    else $error("mirror first colour wrong");
endmodule

// *** inc/scf_pkg.sv ***
// types shared by the clock and frame timing block
// assumes nothing beyond the constants header
package scf_pkg;
  typedef struct packed {
    logic [7:0]  prediv;
    logic [15:0] mult;
    logic [7:0]  vt_sys;
    logic [7:0]  vt_pix;
    logic [7:0]  op_sys;
    logic [7:0]  op_pix;
  } scf_pll_type;

  typedef struct packed {
    logic        en;
    logic        down;
    logic [15:0] period;
    logic [7:0]  depth;
  } scf_ssc_type;

  typedef enum logic [1:0] {SCF_GREEN_R, SCF_RED, SCF_BLUE, SCF_GREEN_B} scf_color_type;

  typedef enum {SCF_STANDBY, SCF_START, SCF_STREAM, SCF_STOP} scf_mode_type;

  typedef struct packed {
    logic          vt_tick;
    logic          op_tick;
    logic          line_blank;
    logic          frame_pad;
    logic          frame_start;
    scf_color_type color;
  } scf_timing_type;

  typedef struct packed {
    logic [15:0] int_long;
    logic [7:0]  analog_gain;
    logic [15:0] digital_gain;
  } scf_expo_type;
endpackage

// *** inc/scf_regs.svh ***
// register offsets, field positions and reset values of the clock and frame timing block
// assumes a control port that presents decoded 16-bit register addresses with 16-bit data
// How it works
// - all internal clock ticks derive from the single reference clock input.
// - pll values written anytime, but only taken into use while in standby.
// - line and frame timing logic advances on the timing pixel clock tick.
// - in standby and start, logic ticks directly on every reference clock edge.
// - clock equals reference times multiplier over prediv times two times sys times pix.
// - spread spectrum off after reset; period, depth programmable; center or down spread.
// - frame rate equals timing pixel clock over line length times frame length.
// - excess line length adds blank pixels; excess frame length adds padding lines.
// - default readout order: first line green red, second blue green.
// - vertical flip makes the first line blue green.
// - horizontal mirror makes the first line red green.
// - no automatic exposure; host writes integration times and gains.
`ifndef SCF_REGS_SVH
`define SCF_REGS_SVH
// ----------------------------------------
// offsets
// ----------------------------------------
`define SCF_A_MODE      16'h0100
`define SCF_A_ORIENT    16'h0101
`define SCF_A_INT_LONG  16'h0202
`define SCF_A_AGAIN     16'h0204
`define SCF_A_DGAIN     16'h020e
`define SCF_A_VT_PIX    16'h0300
`define SCF_A_VT_SYS    16'h0302
`define SCF_A_PREDIV    16'h0304
`define SCF_A_MULT      16'h0306
`define SCF_A_OP_PIX    16'h0308
`define SCF_A_OP_SYS    16'h030a
`define SCF_A_REF_MHZ   16'h0310
`define SCF_A_LINE_LEN  16'h0342
`define SCF_A_X_SIZE    16'h034c
`define SCF_A_Y_SIZE    16'h034e
`define SCF_A_FRAME_LEN 16'h212d
`define SCF_A_SSC_CTRL  16'h3000
`define SCF_A_SSC_PER   16'h3002
`define SCF_A_SSC_DEPTH 16'h3004
`define SCF_A_STATUS    16'h3010
// ----------------------------------------
// fields
// ----------------------------------------
`define SCF_B_STREAM    0
`define SCF_B_MIRROR    0
`define SCF_B_FLIP      1
`define SCF_B_SSC_EN    0
`define SCF_B_SSC_DOWN  1
// ----------------------------------------
// reset values
// ----------------------------------------
`define SCF_R_REF_MHZ   8'h0c
`define SCF_R_PREDIV    8'h02
`define SCF_R_MULT      16'h0084
`define SCF_R_VT_SYS    8'h01
`define SCF_R_VT_PIX    8'h06
`define SCF_R_OP_SYS    8'h01
`define SCF_R_OP_PIX    8'h08
`define SCF_R_LINE_LEN  16'h059e
`define SCF_R_FRAME_LEN 16'h03ff
`define SCF_R_X_SIZE    16'h0518
`define SCF_R_Y_SIZE    16'h03d4
`define SCF_R_SSC_PER   16'h0100
`define SCF_R_SSC_DEPTH 8'h04
`endif

// *** testbench/scf_host_model.sv ***
// host model: drives the register port and notes expected read data
// assumes the bench pops exp_q at the falling edge after each read mark
`timescale 1ns/1ps
module scf_host_model (
  // clock
  input  wire logic        i_clk,
  // register port towards the block
  output logic             o_reg_wr,
  output logic [15:0]      o_reg_addr,
  output logic [15:0]      o_reg_wdata,
  output logic             o_rd_mark
);
  logic [15:0] exp_q[$];

  initial begin
    o_reg_wr    = 1'b0;
    o_reg_addr  = 16'h0000;
    o_reg_wdata = 16'h0000;
    o_rd_mark   = 1'b0;
  end

  // one-cycle write strobe; a fresh call waits for the next falling edge
  task automatic write_reg(input logic [15:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_reg_wr    = 1'b1;
    o_reg_addr  = a;
    o_reg_wdata = d;
    @(negedge i_clk);
    o_reg_wr    = 1'b0;
    // released data must not keep its last value
    o_reg_wdata = ~d;
  endtask

  task automatic read_reg(input logic [15:0] a, input logic [15:0] e);
    @(negedge i_clk);
    o_reg_addr = a;
    o_rd_mark  = 1'b1;
    exp_q.push_back(e);
    @(negedge i_clk);
    o_rd_mark  = 1'b0;
  endtask
endmodule

// *** testbench/sensor_clock_frame_timing_bench.sv ***
// self-checking bench of the clock and frame timing block
// assumes the host model drives the register port at falling edges
`timescale 1ns/1ps
`include "scf_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module sensor_clock_frame_timing_bench
  import scf_pkg::*;
;
  logic           clk, rst_n, reg_wr, rd_mark, rd_seen, streaming;
  logic [15:0]    reg_addr, reg_wdata, reg_rdata, lfsr, e;
  scf_timing_type timing;
  scf_expo_type   expo;
  int             failures = 0;
  int             compares = 0;
  int             vt, op, per, pad, blank;
  logic [15:0] ra[13] = '{`SCF_A_REF_MHZ, `SCF_A_PREDIV, `SCF_A_MULT, `SCF_A_VT_SYS, `SCF_A_VT_PIX,
    `SCF_A_OP_SYS, `SCF_A_OP_PIX, `SCF_A_LINE_LEN, `SCF_A_FRAME_LEN, `SCF_A_SSC_CTRL, `SCF_A_SSC_PER,
    `SCF_A_SSC_DEPTH, 16'h7777};
  logic [15:0] rv[13] = '{16'(`SCF_R_REF_MHZ), 16'(`SCF_R_PREDIV), `SCF_R_MULT, 16'(`SCF_R_VT_SYS),
    16'(`SCF_R_VT_PIX), 16'(`SCF_R_OP_SYS), 16'(`SCF_R_OP_PIX), `SCF_R_LINE_LEN, `SCF_R_FRAME_LEN,
    16'h0000, `SCF_R_SSC_PER, 16'(`SCF_R_SSC_DEPTH), 16'h0000};
  scf_color_type c0[3] = '{SCF_GREEN_R, SCF_RED, SCF_BLUE};
  scf_color_type c1[3] = '{SCF_RED, SCF_GREEN_R, SCF_GREEN_B};
  scf_color_type c2[3] = '{SCF_BLUE, SCF_GREEN_B, SCF_GREEN_R};

  scf_host_model i_host (
    .i_clk       (clk),
    .o_reg_wr    (reg_wr),
    .o_reg_addr  (reg_addr),
    .o_reg_wdata (reg_wdata),
    .o_rd_mark   (rd_mark)
  );

  scf_clock_timing i_dut (
    .i_clk       (clk),
    .i_rst_n     (rst_n),
    .i_reg_wr    (reg_wr),
    .i_reg_addr  (reg_addr),
    .i_reg_wdata (reg_wdata),
    .o_reg_rdata (reg_rdata),
    .o_timing    (timing),
    .o_expo      (expo),
    .o_streaming (streaming)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // read monitor: oldest note against registered read data
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_seen <= 1'b0;
    else rd_seen <= rd_mark;
  end
  always @(negedge clk) begin
    if (rd_seen === 1'b1) begin
      e = i_host.exp_q.pop_front();
      `CHK(reg_rdata, e)
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic timed_out;
    failures++;
    $display("mismatch at %0t: wait ran out", $time);
    test_done();
  endtask

  task automatic wait_stream(input logic lvl);
    for (int n = 0; n < 200; n++) begin
      @(negedge clk);
      if (streaming === lvl) return;
    end
    timed_out();
  endtask

  task automatic wait_frame;
    for (int n = 0; n < 8000; n++) begin
      @(negedge clk);
      if (timing.frame_start === 1'b1) return;
    end
    timed_out();
  endtask

  task automatic count_ticks(input int n, output int v, output int o);
    v = 0;
    o = 0;
    repeat (n) begin
      @(negedge clk);
      v += int'(timing.vt_tick === 1'b1);
      o += int'(timing.op_tick === 1'b1);
    end
  endtask

  task automatic set_stream(input logic on);
    i_host.write_reg(`SCF_A_MODE, {15'h0000, on});
    wait_stream(on);
    repeat (40) @(negedge clk);
  endtask

  initial begin
    rst_n = 1'b0;
    lfsr = 16'h005f;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    // reset values, unmapped read and standby status
    for (int i = 0; i < 13; i++) i_host.read_reg(ra[i], rv[i]);
    i_host.read_reg(`SCF_A_STATUS, 16'h0000);
    $display("test reset_values done");
    // random read-back; 8-bit register reads zero above bit 7
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      i_host.write_reg(`SCF_A_REF_MHZ, lfsr);
      i_host.read_reg(`SCF_A_REF_MHZ, {8'h00, lfsr[7:0]});
      i_host.write_reg(`SCF_A_LINE_LEN, 16'd1438 + {2'b00, lfsr[13:0]});
      i_host.read_reg(`SCF_A_LINE_LEN, 16'd1438 + {2'b00, lfsr[13:0]});
      i_host.write_reg(`SCF_A_FRAME_LEN, lfsr);
      i_host.read_reg(`SCF_A_FRAME_LEN, lfsr);
    end
    i_host.write_reg(`SCF_A_REF_MHZ, 16'h0028);
    i_host.write_reg(`SCF_A_SSC_CTRL, 16'h0003);
    i_host.read_reg(`SCF_A_SSC_CTRL, 16'h0003);
    i_host.write_reg(`SCF_A_SSC_CTRL, 16'h0000);
    $display("test register_access done");
    // exposure values pass straight through, no automatic control
    lfsr = lfsr_next(lfsr);
    i_host.write_reg(`SCF_A_INT_LONG, lfsr);
    i_host.write_reg(`SCF_A_AGAIN, {8'h00, ~lfsr[7:0]});
    i_host.write_reg(`SCF_A_DGAIN, ~lfsr);
    `CHK(expo, {lfsr, ~lfsr[7:0], ~lfsr})
    $display("test exposure done");
    // bypass: one tick per reference edge in standby
    count_ticks(100, vt, op);
    `CHK(vt, 100)
    `CHK(op, 100)
    // pll ratio 3/24 timing chain, 3/32 output chain, set in standby
    i_host.write_reg(`SCF_A_PREDIV, 16'h0002);
    i_host.write_reg(`SCF_A_VT_SYS, 16'h0001);
    i_host.write_reg(`SCF_A_VT_PIX, 16'h0006);
    i_host.write_reg(`SCF_A_OP_SYS, 16'h0001);
    i_host.write_reg(`SCF_A_OP_PIX, 16'h0008);
    i_host.write_reg(`SCF_A_MULT, 16'h0003);
    set_stream(1'b1);
    i_host.read_reg(`SCF_A_STATUS, 16'h0003);
    count_ticks(960, vt, op);
    `CHK(vt >= 119 && vt <= 121, 1'b1)
    `CHK(op >= 89 && op <= 91, 1'b1)
    // a pll change while streaming must wait for standby
    i_host.write_reg(`SCF_A_MULT, 16'h0006);
    count_ticks(960, vt, op);
    `CHK(vt >= 119 && vt <= 121, 1'b1)
    set_stream(1'b0);
    i_host.read_reg(`SCF_A_STATUS, 16'h0000);
    set_stream(1'b1);
    count_ticks(960, vt, op);
    `CHK(vt >= 239 && vt <= 241, 1'b1)
    `CHK(op >= 179 && op <= 181, 1'b1)
    set_stream(1'b0);
    // spread set in standby; period 0 steps the offset every edge, down mean -2, center mean 0
    i_host.write_reg(`SCF_A_SSC_PER, 16'h0000);
    i_host.write_reg(`SCF_A_SSC_DEPTH, 16'h0004);
    for (int i = 0; i < 2; i++) begin
      i_host.write_reg(`SCF_A_SSC_CTRL, 16'(3 - 2 * i));
      set_stream(1'b1);
      count_ticks(960, vt, op);
      `CHK(vt >= 159 + 80 * i && vt <= 161 + 80 * i, 1'b1)
      `CHK(op >= 119 + 60 * i && op <= 121 + 60 * i, 1'b1)
      set_stream(1'b0);
    end
    i_host.write_reg(`SCF_A_SSC_CTRL, 16'h0000);
    $display("test pll_rates done");
    // short frame at full tick rate: 4 lines of 1438, 2 of them padding
    i_host.write_reg(`SCF_A_MULT, 16'h0084);
    i_host.write_reg(`SCF_A_LINE_LEN, 16'd1438);
    i_host.write_reg(`SCF_A_FRAME_LEN, 16'd4);
    i_host.write_reg(`SCF_A_Y_SIZE, 16'd2);
    set_stream(1'b1);
    wait_frame();
    per = 0;
    pad = 0;
    blank = 0;
    do begin
      @(negedge clk);
      per++;
      pad += int'(timing.frame_pad === 1'b1);
      blank += int'(timing.line_blank === 1'b1 && timing.frame_pad === 1'b0);
    end while (timing.frame_start !== 1'b1 && per < 8000);
    `CHK(per, 5752)
    `CHK(pad, 2876)
    `CHK(blank, 268)
    $display("test frame_timing done");
    // first pixels of the first two lines for plain, mirrored and flipped orientation
    for (int i = 0; i < 3; i++) begin
      i_host.write_reg(`SCF_A_ORIENT, 16'(i));
      wait_frame();
      wait_frame();
      `CHK(timing.color, c0[i])
      @(negedge clk);
      `CHK(timing.color, c1[i])
      repeat (1437) @(negedge clk);
      `CHK(timing.color, c2[i])
    end
    set_stream(1'b0);
    $display("test bayer_order done");
    repeat (4) @(negedge clk);
    test_done();
  end
endmodule
